// [src/cmm_mem_core.v]
// Memory subsystem: code prefetch engine, internal RAM decode, stack and on-chip external RAM.
// What this block does
// RULE1: Code memory is read two bytes per access and handed to the core.
// RULE2: Straight-line code runs with no fetch stalls despite 40 ns code access.
// RULE3: A branch stalls the core at most two clock cycles.
// RULE4: Prefetch control bit 5 enables prefetching and resets to one.
// RULE5: Prefetch control bits 7:6 and 4:0 read zero and ignore writes.
// RULE6: Software should clear prefetch enable before suspend to save power.
// RULE7: Code memory is one block from 0x0000, ending 0x3FFF or 0x1FFF.
// RULE8: On the larger part 0x3E00 to 0x3FFF is kept for factory data.
// RULE9: Code memory is read-only; single bytes are readable as constants.
// RULE10: A one-byte variant code is readable at code address 0x3FF9.
// RULE11: A per-device serial number is readable at 0x3FFC to 0x3FFF.
// RULE12: Internal RAM covers 0x00-0xFF; lower half by direct or indirect access.
// RULE13: Above 0x7F direct goes to special registers, indirect to upper RAM.
// RULE14: Addresses 0x00-0x1F form four register banks chosen by status bits 3,4.
// RULE15: Indirect modes use registers 0 and 1 of the active bank as pointers.
// RULE16: Bytes 0x20-0x2F form 128 bits, bit address 8*offset plus position.
// RULE17: Bit or byte access follows the instruction's operand kind.
// RULE18: Push writes at pointer plus one then increments the pointer.
// RULE19: Reset sets the stack pointer to 0x07.
// RULE20: Eight-bit external moves take the high address byte from the page register.
// RULE21: With the window off, 16-bit external moves ignore the top six address bits.
// RULE22: Bank field 00..11 selects 0x00, 0x08, 0x10 or 0x18 register groups.
// RULE23: Page register gives three page bits, higher bits read zero.
// RULE24: With the window on, 0x0400-0x04FF reaches FIFO RAM instead of normal RAM.
// RULE25: With prefetch off every fetch waits for its own code memory read, except variant code, serial and above-block fetches.
// RULE26: The stack pointer wraps inside internal RAM and never reaches special registers.
`default_nettype none
`include "cmm_mem_consts.vh"

module cmm_mem_core #(
  parameter              CODE_BYTES = 16384,
  parameter [7:0]        DEV_ID     = 8'h5a,        // Arbitrary variant code.
  parameter [31:0]       SERIAL     = 32'h00000000  // Per-device serial, set at build.
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire            codeReq,
  input  wire [15:0]     codeAddr,
  output wire            codeReady,
  output wire [7:0]      codeData,
  output wire            memRdEn,
  output wire [12:0]     memRdAddr,
  input  wire [15:0]     memRdData,
  input  wire [1:0]      bankSelectField,
  input  wire            ramReq,
  input  wire            ramWe,
  input  wire [2:0]      ramMode,
  input  wire [7:0]      ramAddr,
  input  wire [7:0]      ramWData,
  output reg             ramAck,
  output reg  [7:0]      ramRData,
  output wire            sfrReq,
  output wire            sfrWe,
  output wire [7:0]      sfrAddr,
  output wire            sfrBitAccess,
  output wire [2:0]      sfrBitSel,
  output wire [7:0]      sfrWData,
  input  wire [7:0]      sfrRData,
  input  wire            fifoWindowEnable,
  input  wire            xReq,
  input  wire            xWe,
  input  wire            xWide,
  input  wire [15:0]     xAddr,
  input  wire [7:0]      xWData,
  output reg             xAck,
  output reg  [7:0]      xRData,
  output wire            fifoReq,
  output wire            fifoWe,
  output wire [7:0]      fifoAddr,
  output wire [7:0]      fifoWData,
  input  wire [7:0]      fifoRData,
  output wire            prefetchOn
);

  // Integer forms first, so that each sized copy cuts its width on purpose.
  localparam integer WORDS_I   = CODE_BYTES / 2;
  localparam integer CODETOP_I = CODE_BYTES - 1;
  localparam integer LATM1_I   = `CMM_CODE_LAT - 1;
  localparam [14:0]  WORDS     = WORDS_I[14:0];
  localparam [15:0]  CODETOP   = CODETOP_I[15:0];
  localparam [1:0]   LATM1     = LATM1_I[1:0];

  // Prefetch engine state: current pair, next pair and one read in flight.
  reg        curValid_reg;
  reg [14:0] curTag_reg;
  reg [15:0] curData_reg;
  reg        nxtValid_reg;
  reg [14:0] nxtTag_reg;
  reg [15:0] nxtData_reg;
  reg        busy_reg;
  reg [14:0] busyTag_reg;
  reg [1:0]  cnt_reg;
  // Prefetch enable, stack pointer and page select kept in this block.
  reg        prefetch_on_bit_reg;
  reg [7:0]  sp_reg;
  reg [2:0]  page_reg;
  // Internal RAM and on-chip external RAM arrays; neither is cleared by reset.
  reg [7:0]  iram [0:255];
  reg [7:0]  on_chip_ext_ram [0:1023];

  // Fetch decode: hits on the two slots, a read landing now, and the overlays.
  wire [14:0] reqTag   = codeAddr[15:1];
  wire        land     = busy_reg && (cnt_reg == 2'h0);
  wire        isId     = (codeAddr == `CMM_ID_ADDR);
  wire        isSer    = (codeAddr >= `CMM_SER_BASE) && (codeAddr <= `CMM_SER_TOP);
  wire        overlay  = isId || isSer || (codeAddr > CODETOP);
  wire        hitCur   = prefetchOn && curValid_reg && (curTag_reg == reqTag);
  wire        hitNxt   = prefetchOn && nxtValid_reg && (nxtTag_reg == reqTag);
  wire        landHit  = land && (busyTag_reg == reqTag) && codeReq;
  wire        inFlight = busy_reg && !land && (busyTag_reg == reqTag);
  wire        missNeed = codeReq && !overlay && !hitCur && !hitNxt && !landHit && !inFlight;

  // Read-ahead: the word after the one the core uses now, unless already held.
  wire [14:0] pfBase   = landHit ? busyTag_reg : ((codeReq && hitNxt) ? nxtTag_reg : curTag_reg);
  wire [14:0] pfTag    = pfBase + 15'h0001;
  wire        pfHave   = nxtValid_reg && (nxtTag_reg == pfTag) && !(codeReq && hitNxt);
  wire        pfNeed   = prefetchOn && (curValid_reg || landHit) && (!busy_reg || land) &&
                         !pfHave && (pfTag < WORDS) && !(busy_reg && busyTag_reg == pfTag);
  wire        issue    = missNeed || (!missNeed && pfNeed);
  wire [14:0] issueTag = missNeed ? reqTag : pfTag;

  // Code memory read port and the fetch answer; a miss always wins the port.
  assign prefetchOn = prefetch_on_bit_reg;                                   // RULE4
  assign memRdEn    = issue;                                      // RULE1
  assign memRdAddr  = issueTag[12:0];
  assign codeReady  = codeReq && (overlay || hitCur || hitNxt || landHit); // RULE25

  // Byte chosen from the two-byte word; even address takes the low byte.
  wire [15:0] pairData = landHit ? memRdData : (hitCur ? curData_reg : nxtData_reg);
  wire [7:0]  pairByte = codeAddr[0] ? pairData[15:8] : pairData[7:0];
  wire [1:0]  serIdx   = codeAddr[1:0];
  wire [7:0]  serByte  = SERIAL[{serIdx, 3'b000} +: 8];
  // Factory overlays win over the array; space above the block reads zero.
  assign codeData = isId ? DEV_ID :                               // RULE10
                    isSer ? serByte :                             // RULE11 RULE8
                    (codeAddr > CODETOP) ? 8'h00 : pairByte;      // RULE7 RULE9

  // Current slot: a landed pair the core wants now, or the next pair moved up.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      curValid_reg <= 1'b0;
      curTag_reg   <= 15'h0000;
      curData_reg  <= 16'h0000;
    end else begin
      if (landHit || (land && !nxtValid_reg && !prefetchOn)) begin
        curValid_reg <= 1'b1;                                     // RULE2
        curTag_reg   <= busyTag_reg;
        curData_reg  <= memRdData;
      end else if (codeReq && hitNxt) begin
        curValid_reg <= 1'b1;                                     // RULE2
        curTag_reg   <= nxtTag_reg;
        curData_reg  <= nxtData_reg;
      end
    end
  end

  // Next slot: a pair read ahead waits here; a landing wins over a clear.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nxtValid_reg <= 1'b0;
      nxtTag_reg   <= 15'h0000;
      nxtData_reg  <= 16'h0000;
    end else begin
      if (land && !landHit) begin
        nxtValid_reg <= 1'b1;
        nxtTag_reg   <= busyTag_reg;
        nxtData_reg  <= memRdData;
      end else if ((codeReq && hitNxt) || missNeed) begin
        nxtValid_reg <= 1'b0;
      end
    end
  end

  // Read tracker: one word read in flight, counted down to its landing cycle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg     <= 1'b0;
      busyTag_reg  <= 15'h0000;
      cnt_reg      <= 2'h0;
    end else begin
      if (issue) begin
        busy_reg    <= 1'b1;                                      // RULE3
        busyTag_reg <= issueTag;
        cnt_reg     <= LATM1;
      end else if (land) begin
        busy_reg    <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg     <= cnt_reg - 2'h1;
      end
    end
  end

  // Internal RAM address decode for every access mode.
  reg  [7:0] tgt;
  reg        toSfr;
  reg        isBit;
  reg  [2:0] bitPos;
  wire [7:0] idxAddr = {3'b000, bankSelectField, 2'b00, ramAddr[0]}; // RULE15
  wire [7:0] idxPtr  = iram[idxAddr];
  wire [7:0] spInc   = sp_reg + 8'h01;                            // RULE26
  always @* begin
    tgt    = ramAddr;
    toSfr  = 1'b0;
    isBit  = 1'b0;
    bitPos = ramAddr[2:0];
    case (ramMode)
      `CMM_MODE_DIRECT: begin
        toSfr = (ramAddr >= `CMM_UPPER_BASE);                     // RULE13 RULE12
      end
      `CMM_MODE_INDIRECT: begin
        tgt = idxPtr;                                             // RULE13
      end
      `CMM_MODE_REG: begin
        tgt = {3'b000, bankSelectField, ramAddr[2:0]};            // RULE14 RULE22
      end
      `CMM_MODE_BIT: begin
        isBit = 1'b1;                                             // RULE17
        if (ramAddr[7]) begin
          tgt   = {ramAddr[7:3], 3'b000};
          toSfr = 1'b1;
        end else begin
          tgt = `CMM_BIT_BASE + {4'h0, ramAddr[6:3]};             // RULE16
        end
      end
      `CMM_MODE_PUSH: begin
        tgt = spInc;                                              // RULE18
      end
      `CMM_MODE_POP: begin
        tgt = sp_reg;                                             // RULE26
      end
      default: begin
        tgt = ramAddr;
      end
    endcase
  end

  // Registers held here answer locally; the rest of the special space goes out.
  wire isSp   = toSfr && !isBit && (tgt == `CMM_SP_ADDR);
  wire isPage = toSfr && !isBit && (tgt == `CMM_PAGE_ADDR);
  wire isPfc  = toSfr && !isBit && (tgt == `CMM_PFC_ADDR);
  wire isLocal = isSp || isPage || isPfc;
  assign sfrReq       = ramReq && toSfr && !isLocal;
  assign sfrWe        = ramWe;
  assign sfrAddr      = tgt;
  assign sfrBitAccess = isBit;
  assign sfrBitSel    = bitPos;
  assign sfrWData     = ramWData;

  wire [7:0] ramByte = iram[tgt];
  wire [7:0] locByte = isSp ? sp_reg :
                       isPage ? {5'h00, page_reg} :                // RULE23
                       {2'b00, prefetch_on_bit_reg, 5'h00};                  // RULE5
  wire [7:0] srcByte = toSfr ? (isLocal ? locByte : sfrRData) : ramByte;
  wire [7:0] bitMask = 8'h01 << bitPos;
  wire [7:0] merged  = ramWData[0] ? (ramByte | bitMask) : (ramByte & ~bitMask);

  // Read answer: acknowledge one cycle after each request, read data with it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ramAck   <= 1'b0;
      ramRData <= 8'h00;
    end else begin
      ramAck <= ramReq;
      if (ramReq && !ramWe) begin
        ramRData <= isBit ? {7'h00, srcByte[bitPos]} : srcByte;   // RULE17
      end
    end
  end

  // Stack pointer: stack moves take priority over a direct write to it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg   <= `CMM_SP_RESET;                                  // RULE19
    end else begin
      if (ramReq && ramMode == `CMM_MODE_PUSH) begin
        sp_reg <= spInc;                                          // RULE18
      end else if (ramReq && ramMode == `CMM_MODE_POP) begin
        sp_reg <= sp_reg - 8'h01;                                 // RULE26
      end else if (ramReq && ramWe && isSp) begin
        sp_reg <= ramWData;
      end
    end
  end

  // Page register: only the three page bits are kept.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_reg <= `CMM_PAGE_RESET;
    end else begin
      if (ramReq && ramWe && isPage) begin
        page_reg <= ramWData[2:0];                                // RULE23
      end
    end
  end

  // Prefetch enable: the one writable bit of the prefetch control register.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prefetch_on_bit_reg <= `CMM_PFC_RESET;                                 // RULE4
    end else begin
      if (ramReq && ramWe && isPfc) begin
        prefetch_on_bit_reg <= ramWData[`CMM_PFC_EN_BIT];                    // RULE4 RULE5
      end
    end
  end

  // Internal RAM array writes; push always lands in RAM.
  always @(posedge clk) begin
    if (ramReq && !toSfr && (ramWe || ramMode == `CMM_MODE_PUSH)) begin
      iram[tgt] <= isBit ? merged : ramWData;                     // RULE12 RULE16
    end
  end

  // External RAM address: page register for 8-bit moves, modulo aliasing otherwise.
  wire [15:0] xFull  = xWide ? xAddr : {5'h00, page_reg, xAddr[7:0]}; // RULE20
  wire        inWin  = fifoWindowEnable && (xFull[15:8] == `CMM_FIFO_PAGE); // RULE24
  wire [9:0]  xIdx   = xFull[9:0];                                // RULE21
  assign fifoReq   = xReq && inWin;
  assign fifoWe    = xWe;
  assign fifoAddr  = xFull[7:0];
  assign fifoWData = xWData;

  // External RAM array and its answer.
  always @(posedge clk) begin
    if (xReq && xWe && !inWin) begin
      on_chip_ext_ram[xIdx] <= xWData;                                       // RULE21
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xAck   <= 1'b0;
      xRData <= 8'h00;
    end else begin
      xAck <= xReq;
      if (xReq && !xWe) begin
        xRData <= inWin ? fifoRData : on_chip_ext_ram[xIdx];                 // RULE24
      end
    end
  end

endmodule // cmm_mem_core
`default_nettype wire

// [src/cmm_mem_consts.vh]
// Constants for the memory subsystem: offsets, field positions, reset values and timing.
`ifndef CMM_MEM_CONSTS_VH
`define CMM_MEM_CONSTS_VH

// Special function space offsets answered inside this block.
`define CMM_SP_ADDR        8'h81
`define CMM_PAGE_ADDR      8'haa
`define CMM_PFC_ADDR       8'haf

// Field positions and reset values.
`define CMM_PFC_EN_BIT     5
`define CMM_PFC_RESET      1'b1
`define CMM_SP_RESET       8'h07
`define CMM_PAGE_RESET     3'h0

// Timing: code memory access time against the system clock period.
`define CMM_CLK_NS         20
`define CMM_CODE_NS        40
`define CMM_CODE_LAT       ((`CMM_CODE_NS + `CMM_CLK_NS - 1) / `CMM_CLK_NS)

// Program memory landmarks.
`define CMM_ID_ADDR        16'h3ff9
`define CMM_SER_BASE       16'h3ffc
`define CMM_SER_TOP        16'h3fff
`define CMM_RSV_BASE       16'h3e00

// Data memory landmarks.
`define CMM_UPPER_BASE     8'h80
`define CMM_BIT_BASE       8'h20
`define CMM_FIFO_PAGE      8'h04

// Internal RAM access modes.
`define CMM_MODE_DIRECT    3'h0
`define CMM_MODE_INDIRECT  3'h1
`define CMM_MODE_REG       3'h2
`define CMM_MODE_BIT       3'h3
`define CMM_MODE_PUSH      3'h4
`define CMM_MODE_POP       3'h5

`endif

// [bench/cmm_mem_core_assertions.sv]
// Concurrent checks on the ports of the memory subsystem.
`default_nettype none
`include "cmm_mem_consts.vh"
module cmm_mem_core_assertions #(
  parameter [7:0]  DEV_ID = 8'h00,
  parameter [31:0] SERIAL = 32'h0
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        codeReq,
  input wire logic [15:0] codeAddr,
  input wire logic        codeReady,
  input wire logic [7:0]  codeData,
  input wire logic        memRdEn,
  input wire logic [12:0] memRdAddr,
  input wire logic        ramReq,
  input wire logic        ramWe,
  input wire logic [2:0]  ramMode,
  input wire logic [7:0]  ramAddr,
  input wire logic [7:0]  ramWData,
  input wire logic        ramAck,
  input wire logic [7:0]  ramRData,
  input wire logic        sfrReq,
  input wire logic [7:0]  sfrAddr,
  input wire logic        xReq,
  input wire logic        xWide,
  input wire logic [15:0] xAddr,
  input wire logic        xAck,
  input wire logic        fifoWindowEnable,
  input wire logic        fifoReq,
  input wire logic        prefetchOn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A fetch starts on a fresh request or right after a consumed byte.
  sequence s_start;
    codeReq && (!$past(codeReq) || $past(codeReady)) && codeAddr < `CMM_RSV_BASE;
  endsequence
  // An unbuffered fetch issues its word read and answers two cycles later.
  sequence s_slow;
    memRdEn && memRdAddr == codeAddr[13:1] && !codeReady ##1 !codeReady ##1 codeReady;
  endsequence
  // Code side timing and fixed code locations.
  AST_BRANCH_STALL: assert property (s_start |-> ##[0:2] codeReady)
    else $error("fetch stalled more than two cycles");
  AST_NO_PREFETCH: assert property (s_start ##0 !prefetchOn |-> s_slow)
    else $error("fetch without prefetch mistimed");
  AST_DEV_ID: assert property (codeReq && codeAddr == `CMM_ID_ADDR |-> codeReady && codeData == DEV_ID)
    else $error("variant code wrong");
  AST_SERIAL: assert property (codeReq && codeAddr[15:2] == 14'h0fff
    |-> codeReady && codeData == SERIAL[8*codeAddr[1:0] +: 8])
    else $error("serial byte wrong");
  // Data side decode and handshakes.
  AST_RAM_ACK: assert property (ramReq |=> ramAck)
    else $error("internal RAM not acknowledged");
  AST_PFC_READ: assert property (ramReq && !ramWe && ramMode == `CMM_MODE_DIRECT
    && ramAddr == `CMM_PFC_ADDR |=> ramRData == {2'h0, $past(prefetchOn), 5'h00})
    else $error("prefetch control read wrong");
  AST_PFC_WRITE: assert property (ramReq && ramWe && ramMode == `CMM_MODE_DIRECT
    && ramAddr == `CMM_PFC_ADDR |=> prefetchOn == $past(ramWData[5]))
    else $error("prefetch enable not written");
  AST_SFR_SPLIT: assert property (ramReq && ramMode == `CMM_MODE_DIRECT && ramAddr[7]
    && ramAddr != `CMM_SP_ADDR && ramAddr != `CMM_PAGE_ADDR && ramAddr != `CMM_PFC_ADDR
    |-> sfrReq && sfrAddr == ramAddr)
    else $error("direct upper access not forwarded");
  AST_UPPER_RAM: assert property (ramReq && ramMode inside {`CMM_MODE_INDIRECT,
    `CMM_MODE_PUSH, `CMM_MODE_POP} |-> !sfrReq)
    else $error("indirect or stack access reached special space");
  AST_FIFO_MAP: assert property (xReq && xWide
    |-> fifoReq == (fifoWindowEnable && xAddr[15:8] == `CMM_FIFO_PAGE))
    else $error("FIFO window decode wrong");
  AST_X_ACK: assert property (xAck == $past(xReq))
    else $error("external RAM acknowledge wrong");
endmodule // cmm_mem_core_assertions
bind cmm_mem_core cmm_mem_core_assertions #(.DEV_ID(DEV_ID), .SERIAL(SERIAL)) i_chk (
  .clk(clk), .rst_n(rst_n), .codeReq(codeReq), .codeAddr(codeAddr),
  .codeReady(codeReady), .codeData(codeData), .memRdEn(memRdEn), .memRdAddr(memRdAddr),
  .ramReq(ramReq), .ramWe(ramWe), .ramMode(ramMode), .ramAddr(ramAddr),
  .ramWData(ramWData), .ramAck(ramAck), .ramRData(ramRData), .sfrReq(sfrReq),
  .sfrAddr(sfrAddr), .xReq(xReq), .xWide(xWide), .xAddr(xAddr), .xAck(xAck),
  .fifoWindowEnable(fifoWindowEnable), .fifoReq(fifoReq), .prefetchOn(prefetchOn));
`default_nettype wire

// [bench/cmm_code_mem_model.sv]
// Code memory model that answers word reads two cycles after the request.
`default_nettype none
module cmm_code_mem_model (
  input  wire logic        clk,
  input  wire logic        memRdEn,
  input  wire logic [12:0] memRdAddr,
  output var  logic [15:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] a1, a2;
  logic        v1, v2;
  logic [15:0] w;
  // Two pipe stages give the slow array access at this clock rate.
  always @(posedge clk) begin
    a1 <= memRdAddr;
    v1 <= memRdEn;
    a2 <= a1;
    v2 <= v1;
  end
  // Outside the valid cycle the word is inverted so stale data never passes.
  always_comb begin
    w = {{a2[6:0], 1'b1} ^ a2[12:5], {a2[6:0], 1'b0} ^ a2[12:5]};
    memRdData = v2 ? w : ~w;
  end
endmodule // cmm_code_mem_model
`default_nettype wire

// [bench/test_cmm_mem_core.sv]
// Testbench driving fetch, internal RAM and external RAM traffic.
`default_nettype none
`include "cmm_mem_consts.vh"
module test_cmm_mem_core;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  devId    = 8'h96;        // Arbitrary variant code.
  localparam logic [31:0] serialNo = 32'h1234abcd;
  logic        clk = 0, rst_n = 0, codeReq = 0, ramReq = 0, ramWe = 0;
  logic        xReq = 0, xWe = 0, xWide = 0, fifoWin = 0;
  logic [15:0] codeAddr = 0, xAddr = 0;
  logic [7:0]  ramAddr = 0, ramWData = 0, xWData = 0;
  logic [2:0]  ramMode = 0;
  logic [1:0]  bankSel = 0;
  wire logic   codeReady, memRdEn, ramAck, xAck, prefetchOn;
  wire logic [7:0]  codeData, ramRData, xRData;
  wire logic [12:0] memRdAddr;
  wire logic [15:0] memRdData;
  int          n_mismatch = 0, n_tests = 0, w, s;
  // Design, with special and FIFO read data held at fixed patterns.
  cmm_mem_core #(.DEV_ID(devId), .SERIAL(serialNo)) i_dut (
    .clk(clk), .rst_n(rst_n), .codeReq(codeReq), .codeAddr(codeAddr),
    .codeReady(codeReady), .codeData(codeData), .memRdEn(memRdEn),
    .memRdAddr(memRdAddr), .memRdData(memRdData), .bankSelectField(bankSel),
    .ramReq(ramReq), .ramWe(ramWe), .ramMode(ramMode), .ramAddr(ramAddr),
    .ramWData(ramWData), .ramAck(ramAck), .ramRData(ramRData), .sfrReq(),
    .sfrWe(), .sfrAddr(), .sfrBitAccess(), .sfrBitSel(), .sfrWData(),
    .sfrRData(8'hc3), .fifoWindowEnable(fifoWin), .xReq(xReq), .xWe(xWe),
    .xWide(xWide), .xAddr(xAddr), .xWData(xWData), .xAck(xAck), .xRData(xRData),
    .fifoReq(), .fifoWe(), .fifoAddr(), .fifoWData(), .fifoRData(8'h3c),
    .prefetchOn(prefetchOn));
  cmm_code_mem_model i_mem (.clk(clk), .memRdEn(memRdEn), .memRdAddr(memRdAddr),
    .memRdData(memRdData));
  // Free running system clock.
  always #10 clk = ~clk;
  // Expected code byte, built the same way the memory model forms its words.
  function automatic logic [7:0] cb(input logic [15:0] b);
    return b[7:0] ^ b[13:6];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One internal RAM or special access; read data is taken with the acknowledge.
  task automatic ram(input logic we, input logic [2:0] m, input logic [7:0] a, d, e);
    @(posedge clk) #2;
    {ramReq, ramWe, ramMode, ramAddr, ramWData} = {1'b1, we, m, a, d};
    @(posedge clk) #2;
    ramReq = 0;
    chk(ramAck, 1);
    if (!we) chk(ramRData, e);
  endtask
  // One external RAM access in pointer or paged form.
  task automatic xr(input logic we, wide, input logic [15:0] a, input logic [7:0] d, e);
    @(posedge clk) #2;
    {xReq, xWe, xWide, xAddr, xWData} = {1'b1, we, wide, a, d};
    @(posedge clk) #2;
    xReq = 0;
    chk(xAck, 1);
    if (!we) chk(xRData, e);
  endtask
  // Holds a code request until the byte is given; stalls are counted in w and s.
  task automatic fetch(input logic [15:0] a, input logic [7:0] e);
    codeReq = 1;
    codeAddr = a;
    w = 0;
    #1;
    while (codeReady !== 1'b1) begin
      if (++w > 8) begin
        n_mismatch++;
        tally_and_finish();
      end
      @(posedge clk) #2;
    end
    chk(codeData, e);
    s += w;
    @(posedge clk) #2;
  endtask
  // Main sequence of scenarios.
  initial begin
    repeat (4) @(posedge clk);
    #2 rst_n = 1;
    chk(prefetchOn, 1);
    ram(0, `CMM_MODE_DIRECT, `CMM_PFC_ADDR, 0, 8'h20);
    ram(0, `CMM_MODE_DIRECT, `CMM_SP_ADDR, 0, 8'h07);
    ram(1, `CMM_MODE_DIRECT, `CMM_PFC_ADDR, 8'hdf, 0);
    ram(0, `CMM_MODE_DIRECT, `CMM_PFC_ADDR, 0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      fetch(16'h0100 + i, cb(16'h0100 + i));
      chk(w, 2);
    end
    codeReq = 0;
    ram(1, `CMM_MODE_DIRECT, `CMM_PFC_ADDR, 8'hff, 0);
    ram(0, `CMM_MODE_DIRECT, `CMM_PFC_ADDR, 0, 8'h20);
    fetch(16'h0200, cb(16'h0200));
    chk(w <= 2, 1);
    s = 0;
    for (int i = 1; i < 16; i++) fetch(16'h0200 + i, cb(16'h0200 + i));
    chk(s, 0);
    fetch(16'h3ff9, devId);
    for (int i = 0; i < 4; i++) fetch(16'h3ffc + i, serialNo >> (8 * i));
    fetch(16'h4000, 8'h00);
    codeReq = 0;
    for (int b = 0; b < 4; b++) begin
      bankSel = b[1:0];
      ram(1, `CMM_MODE_REG, 8'h03, 8'h40 + b, 0);
      ram(0, `CMM_MODE_DIRECT, 8'h03 + 8 * b, 0, 8'h40 + b);
    end
    bankSel = 2'h1;
    ram(1, `CMM_MODE_DIRECT, 8'h08, 8'h90, 0);
    ram(1, `CMM_MODE_INDIRECT, 8'h00, 8'h77, 0);
    ram(0, `CMM_MODE_INDIRECT, 8'h00, 0, 8'h77);
    ram(0, `CMM_MODE_DIRECT, 8'h90, 0, 8'hc3);
    ram(1, `CMM_MODE_DIRECT, 8'h09, 8'h35, 0);
    ram(1, `CMM_MODE_DIRECT, 8'h35, 8'he1, 0);
    ram(0, `CMM_MODE_INDIRECT, 8'h01, 0, 8'he1);
    ram(1, `CMM_MODE_DIRECT, 8'h22, 8'h00, 0);
    ram(1, `CMM_MODE_BIT, 8'h13, 8'h01, 0);
    ram(0, `CMM_MODE_DIRECT, 8'h22, 0, 8'h08);
    ram(0, `CMM_MODE_BIT, 8'h13, 0, 8'h01);
    ram(1, `CMM_MODE_PUSH, 8'h00, 8'ha5, 0);
    ram(0, `CMM_MODE_DIRECT, 8'h08, 0, 8'ha5);
    ram(0, `CMM_MODE_DIRECT, `CMM_SP_ADDR, 0, 8'h08);
    ram(1, `CMM_MODE_DIRECT, `CMM_SP_ADDR, 8'hff, 0);
    ram(1, `CMM_MODE_PUSH, 8'h00, 8'h5c, 0);
    ram(0, `CMM_MODE_DIRECT, 8'h00, 0, 8'h5c);
    ram(0, `CMM_MODE_POP, 8'h00, 0, 8'h5c);
    ram(0, `CMM_MODE_DIRECT, `CMM_SP_ADDR, 0, 8'hff);
    ram(1, `CMM_MODE_DIRECT, `CMM_PAGE_ADDR, 8'hfb, 0);
    ram(0, `CMM_MODE_DIRECT, `CMM_PAGE_ADDR, 0, 8'h03);
    xr(1, 0, 16'h0045, 8'h11, 0);
    xr(0, 1, 16'h0345, 0, 8'h11);
    xr(0, 1, 16'hf345, 0, 8'h11);
    xr(1, 1, 16'h0010, 8'h22, 0);
    fifoWin = 1;
    xr(0, 1, 16'h0410, 0, 8'h3c);
    fifoWin = 0;
    xr(0, 1, 16'h0410, 0, 8'h22);
    tally_and_finish();
  end
endmodule // test_cmm_mem_core
`default_nettype wire
